// ---- rtl/shs_sequencer.sv ----
`timescale 1ns/100ps
// home-return sequencer: dogless index, dog-based with automatic
// return, and automatic positioning to an established home
module shs_sequencer (
  input  wire logic                          mclk_i,
  input  wire logic                          arst_n_i,
  input  wire shs_pkg::shs_param_t           param_i,
  input  wire logic [shs_pkg::FILT_W-1:0]    input_filter_time_param_i,
  input  wire logic                          auto_manual_select_i,
  input  wire logic [7:0]                    point_table_select_i,
  input  wire logic [3:0]                    bcd_digit_select_i,
  input  wire logic                          forward_start_i,
  input  wire logic                          reverse_start_input_i,
  input  wire logic                          proximity_dog_i,
  input  wire logic                          forward_stroke_end_i,
  input  wire logic                          reverse_stroke_end_i,
  input  wire logic                          index_pulse_i,
  input  wire logic                          motion_done_i,
  input  wire logic [shs_pkg::POS_W-1:0]     feedback_pos_i,
  output shs_pkg::shs_motion_t               motion_o,
  output logic [shs_pkg::POS_W-1:0]          target_pos_o,
  output logic                               target_valid_o,
  output logic                               pos_load_o,
  output logic [shs_pkg::POS_W-1:0]          pos_load_value_o,
  output logic                               home_established_o,
  output logic                               home_busy_o,
  output logic                               home_return_incomplete_alarm_o
);
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_DOGLESS_SEEK,
    ST_DOG_SEEK,
    ST_ESCAPE_DOG,
    ST_SEARCH_BEYOND,
    ST_REVERSED,
    ST_CREEP,
    ST_INDEX_WAIT,
    ST_SHIFT,
    ST_LOAD,
    ST_AUTO_POS,
    ST_ALARM
  } shs_state_t;

  typedef struct packed {
    shs_state_t                   state;
    shs_pkg::shs_motion_t         motion;
    logic [shs_pkg::POS_W-1:0]    target;
    logic                         target_valid;
    logic                         pos_load;
    logic [shs_pkg::POS_W-1:0]    pos_load_value;
    logic                         home_est;
    logic                         alarm;
    logic                         dog_seen;
    logic                         dog_prev;
    logic                         idx_prev;
    logic                         start_prev;
    logic                         rstart_prev;
  } shs_seq_st_t;

  shs_seq_st_t st_q;
  shs_seq_st_t st_d;

  logic [7:0] in_raw;
  logic [7:0] in_f;
  logic       f_start;
  logic       f_rstart;
  logic       f_dog;
  logic       f_lsp;
  logic       f_lsn;
  logic       f_idx;
  logic       f_mode;
  logic       homing_mode;
  logic       start_edge;
  logic       rstart_edge;
  logic       idx_edge;
  logic       dog_fall;
  logic       dogless;
  logic       in_range;
  shs_pkg::shs_dir_t home_dir;
  shs_pkg::shs_dir_t back_dir;

  // start, dog, stroke-end and auto/manual inputs share one filter so their delays line up
  assign in_raw = {1'b0, auto_manual_select_i, index_pulse_i, reverse_stroke_end_i,
                   forward_stroke_end_i, proximity_dog_i, reverse_start_input_i,
                   forward_start_i};

  shs_filter #(
    .WIDTH  (8),
    .FILT_W (shs_pkg::FILT_W)
  ) u_filter (
    .mclk_i        (mclk_i),
    .arst_n_i      (arst_n_i),
    .filt_cycles_i (input_filter_time_param_i),
    .raw_i         (in_raw),
    .filt_o        (in_f)
  );

  // index pulse is narrow; the filter is bypassed for it past the sync
  logic [1:0] idx_sync_q;
  logic [7:0] pts_s1_q;
  logic [7:0] pts_s2_q;
  logic [3:0] bcd_s1_q;
  logic [3:0] bcd_s2_q;

  // selection bus is only synchronised; it is qualified by the start edge
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      idx_sync_q <= 2'h0;
      pts_s1_q   <= 8'h00;
      pts_s2_q   <= 8'h00;
      bcd_s1_q   <= 4'h0;
      bcd_s2_q   <= 4'h0;
    end
    else
    begin
      idx_sync_q <= {idx_sync_q[0], index_pulse_i};
      pts_s1_q   <= point_table_select_i;
      pts_s2_q   <= pts_s1_q;
      bcd_s1_q   <= bcd_digit_select_i;
      bcd_s2_q   <= bcd_s1_q;
    end
  end

  assign f_start  = in_f[0];
  assign f_rstart = in_f[1];
  assign f_dog    = in_f[2];
  assign f_lsp    = in_f[3];
  assign f_lsn    = in_f[4];
  assign f_mode   = in_f[6];
  assign f_idx    = idx_sync_q[1];

  // homing mode: table select all low, or bcd digits low in bcd mode
  assign homing_mode = f_mode && (param_i.bcd_mode ? (bcd_s2_q == 4'h0)
                                                   : (pts_s2_q == 8'h00));
  assign start_edge  = f_start && !st_q.start_prev;
  assign rstart_edge = f_rstart && !st_q.rstart_prev;
  assign idx_edge    = f_idx && !st_q.idx_prev;
  assign dog_fall    = !f_dog && st_q.dog_prev;
  assign dogless     = param_i.homing_type_param[3:0] == shs_pkg::TYPE_DOGLESS;
  assign in_range    = ($signed(feedback_pos_i) >= $signed(param_i.pos_limit_min)) &&
                       ($signed(feedback_pos_i) <= $signed(param_i.pos_limit_max));
  assign home_dir    = param_i.homing_direction_param ? shs_pkg::SHS_DIR_REV
                                                      : shs_pkg::SHS_DIR_FWD;
  assign back_dir    = param_i.homing_direction_param ? shs_pkg::SHS_DIR_FWD
                                                      : shs_pkg::SHS_DIR_REV;

  // builds a run command with table-1 time constants and no soft limits
  function automatic shs_pkg::shs_motion_t mk_run(input shs_pkg::shs_dir_t dir,
                                                   input logic [shs_pkg::SPD_W-1:0] spd,
                                                   input shs_pkg::shs_param_t p);
    shs_pkg::shs_motion_t m;
    m.run           = 1'b1;
    m.dir           = dir;
    m.speed         = spd;
    m.accel_tc      = p.accel_tc_table1;
    m.decel_tc      = p.decel_tc_table1;
    m.soft_limit_en = 1'b0;
    return m;
  endfunction

  // main sequencing
  always_comb
  begin
    st_d              = st_q;
    st_d.pos_load     = 1'b0;
    st_d.dog_prev     = f_dog;
    st_d.idx_prev     = f_idx;
    st_d.start_prev   = f_start;
    st_d.rstart_prev  = f_rstart;
    unique case (st_q.state)
      ST_IDLE:
      begin
        st_d.motion       = '0;
        st_d.target_valid = 1'b0;
        if (homing_mode && start_edge)
        begin
          st_d.alarm    = 1'b0;
          st_d.dog_seen = 1'b0;
          if (dogless)
          begin
            st_d.motion = mk_run(home_dir, param_i.homing_speed_param, param_i);
            st_d.state  = ST_DOGLESS_SEEK;
          end
          else if (f_dog)
          begin
            // start on the dog: back off first
            st_d.motion = mk_run(back_dir, param_i.homing_speed_param, param_i);
            st_d.state  = ST_ESCAPE_DOG;
          end
          else
          begin
            st_d.motion = mk_run(home_dir, param_i.homing_speed_param, param_i);
            st_d.state  = ST_DOG_SEEK;
          end
        end
        else if (homing_mode && rstart_edge && st_q.home_est && in_range)
        begin
          st_d.motion       = mk_run(shs_pkg::SHS_DIR_NONE, param_i.homing_speed_param,
                                     param_i);
          st_d.target       = param_i.home_position_data_param;
          st_d.target_valid = 1'b1;
          st_d.state        = ST_AUTO_POS;
        end
      end
      ST_DOGLESS_SEEK:
      begin
        if (idx_edge)
        begin
          st_d.motion.run   = 1'b0;
          st_d.target       = feedback_pos_i + param_i.home_shift_param;
          st_d.target_valid = 1'b1;
          st_d.state        = ST_SHIFT;
        end
      end
      ST_DOG_SEEK:
      begin
        if (f_dog)
        begin
          st_d.motion = mk_run(home_dir, param_i.creep_speed_param, param_i);
          st_d.state  = ST_CREEP;
        end
        else if ((home_dir == shs_pkg::SHS_DIR_FWD) ? f_lsp : f_lsn)
        begin
          // beyond the dog: reverse at the stroke end
          st_d.motion = mk_run(back_dir, param_i.homing_speed_param, param_i);
          st_d.state  = ST_REVERSED;
        end
      end
      ST_ESCAPE_DOG:
      begin
        if (!f_dog)
        begin
          st_d.motion = mk_run(home_dir, param_i.homing_speed_param, param_i);
          st_d.state  = ST_DOG_SEEK;
        end
      end
      ST_REVERSED:
      begin
        if (f_dog)
          st_d.dog_seen = 1'b1;
        if (st_q.dog_seen && dog_fall)
        begin
          // past the dog front end: stop, then home again from here
          st_d.motion.run = 1'b0;
          st_d.state      = ST_SEARCH_BEYOND;
        end
        else if (!st_q.dog_seen && ((back_dir == shs_pkg::SHS_DIR_FWD) ? f_lsp : f_lsn))
        begin
          st_d.motion = '0;
          st_d.alarm  = 1'b1;
          st_d.state  = ST_ALARM;
        end
      end
      ST_SEARCH_BEYOND:
      begin
        if (motion_done_i)
        begin
          st_d.motion = mk_run(home_dir, param_i.homing_speed_param, param_i);
          st_d.state  = ST_DOG_SEEK;
        end
      end
      ST_CREEP:
      begin
        if (!f_dog)
          st_d.state = ST_INDEX_WAIT;
      end
      ST_INDEX_WAIT:
      begin
        if (idx_edge)
        begin
          st_d.motion.run   = 1'b0;
          st_d.target       = feedback_pos_i + param_i.home_shift_param;
          st_d.target_valid = 1'b1;
          st_d.state        = ST_SHIFT;
        end
      end
      ST_SHIFT:
      begin
        if (motion_done_i)
        begin
          st_d.target_valid = 1'b0;
          st_d.state        = ST_LOAD;
        end
      end
      ST_LOAD:
      begin
        st_d.pos_load       = 1'b1;
        st_d.pos_load_value = param_i.home_position_data_param;
        st_d.home_est       = 1'b1;
        st_d.motion         = '0;
        st_d.state          = ST_IDLE;
      end
      ST_AUTO_POS:
      begin
        if (motion_done_i)
        begin
          st_d.motion       = '0;
          st_d.target_valid = 1'b0;
          st_d.state        = ST_IDLE;
        end
      end
      ST_ALARM:
      begin
        // alarm holds until a fresh start while in homing mode
        st_d.motion = '0;
        if (homing_mode && start_edge)
        begin
          st_d.alarm = 1'b0;
          st_d.state = ST_IDLE;
        end
      end
    endcase
    // dropping the auto/manual select aborts a move in progress
    if (!f_mode && st_q.state != ST_IDLE && st_q.state != ST_ALARM)
    begin
      st_d.motion       = '0;
      st_d.target_valid = 1'b0;
      st_d.state        = ST_IDLE;
    end
  end

  // absolute mode keeps home over power-on; incremental starts unhomed
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      st_q <= '{state: ST_IDLE, target: shs_pkg::POS_RST,
                pos_load_value: shs_pkg::POS_RST, default: '0};
    else
    begin
      st_q <= st_d;
      if (param_i.absolute_mode)
        st_q.home_est <= 1'b1;
    end
  end

  assign motion_o                       = st_q.motion;
  assign target_pos_o                   = st_q.target;
  assign target_valid_o                 = st_q.target_valid;
  assign pos_load_o                     = st_q.pos_load;
  assign pos_load_value_o               = st_q.pos_load_value;
  assign home_established_o             = st_q.home_est;
  assign home_busy_o                    = st_q.state != ST_IDLE && st_q.state != ST_ALARM;
  assign home_return_incomplete_alarm_o = st_q.alarm;
endmodule // shs_sequencer

// ---- rtl/shs_pkg.sv ----
// Behaviour
// - dogless: home at first index after start
// - type code A selects dogless index method
// - travel direction from direction parameter
// - homing speed until dog detected
// - creep speed after dog detected
// - home offset by shift distance
// - homing uses table 1 accel/decel times
// - completion loads position with home data
// - inputs delayed by filter time
// - start on dog: return off, then home
// - beyond dog: reverse at stroke end
// - stop past dog front, restart homing
// - no dog: stop at stroke end, alarm
// - no software limits during auto return
// - reverse start positions to established home
// - refuse auto positioning outside valid range
// - auto positioning needs home since power-on (absolute mode sets the home flag right after reset, without homing)
package shs_pkg;
  localparam int POS_W  = 32;
  localparam int SPD_W  = 16;
  localparam int TC_W   = 16;
  localparam int FILT_W = 8;
  // lowest digit of homing type selecting the dogless index method
  localparam logic [3:0] TYPE_DOGLESS = 4'ha;
  localparam logic [POS_W-1:0] POS_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    SHS_DIR_NONE,
    SHS_DIR_FWD,
    SHS_DIR_REV
  } shs_dir_t;

  // homing parameter set from the parameter store
  typedef struct packed {
    logic [15:0]      homing_type_param;
    logic             homing_direction_param; // 1 = reverse
    logic [SPD_W-1:0] homing_speed_param;
    logic [SPD_W-1:0] creep_speed_param;
    logic [POS_W-1:0] home_shift_param;
    logic [POS_W-1:0] home_position_data_param;
    logic [TC_W-1:0]  accel_tc_table1;
    logic [TC_W-1:0]  decel_tc_table1;
    logic [POS_W-1:0] pos_limit_min;
    logic [POS_W-1:0] pos_limit_max;
    logic             bcd_mode;
    logic             absolute_mode;
  } shs_param_t;

  // motion command towards the motion generator
  typedef struct packed {
    logic             run;
    shs_dir_t         dir;
    logic [SPD_W-1:0] speed;
    logic [TC_W-1:0]  accel_tc;
    logic [TC_W-1:0]  decel_tc;
    logic             soft_limit_en;
  } shs_motion_t;
endpackage

// ---- rtl/shs_filter.sv ----
`timescale 1ns/100ps
// two-flop sync then hold-time filter on each discrete input
module shs_filter #(
  parameter int WIDTH  = 8,
  parameter int FILT_W = 8
) (
  input  wire logic              mclk_i,
  input  wire logic              arst_n_i,
  input  wire logic [FILT_W-1:0] filt_cycles_i,
  input  wire logic [WIDTH-1:0]  raw_i,
  output logic      [WIDTH-1:0]  filt_o
);
  typedef struct packed {
    logic [WIDTH-1:0]  s1;
    logic [WIDTH-1:0]  s2;
    logic [WIDTH-1:0]  out;
    logic [WIDTH-1:0][FILT_W-1:0] cnt;
  } shs_filt_st_t;

  shs_filt_st_t st_q;
  shs_filt_st_t st_d;

  // a level must stay stable for the filter time before it is taken
  always_comb
  begin
    st_d    = st_q;
    st_d.s1 = raw_i;
    st_d.s2 = st_q.s1;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (st_q.s2[i] == st_q.out[i])
        st_d.cnt[i] = '0;
      else if (st_q.cnt[i] >= filt_cycles_i)
      begin
        st_d.out[i] = st_q.s2[i];
        st_d.cnt[i] = '0;
      end
      else
        st_d.cnt[i] = st_q.cnt[i] + 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign filt_o = st_q.out;
endmodule // shs_filter

// ---- sim/shs_props.sv ----
`timescale 1ns/100ps
// homing outputs tied to parameters and inputs
module shs_props (
  input wire logic                      mclk_i,
  input wire logic                      arst_n_i,
  input wire shs_pkg::shs_param_t       param_i,
  input wire logic                      index_pulse_i,
  input wire shs_pkg::shs_motion_t      motion_o,
  input wire logic                      target_valid_o,
  input wire logic                      pos_load_o,
  input wire logic [shs_pkg::POS_W-1:0] pos_load_value_o,
  input wire logic                      home_established_o,
  input wire logic                      home_busy_o,
  input wire logic                      home_return_incomplete_alarm_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i);
  logic              dl;
  logic              hr;
  shs_pkg::shs_dir_t hd;
  // dogless type, directed travel and its expected direction
  assign dl = param_i.homing_type_param[3:0] == shs_pkg::TYPE_DOGLESS;
  assign hr = motion_o.run && motion_o.dir != shs_pkg::SHS_DIR_NONE;
  assign hd = param_i.homing_direction_param ? shs_pkg::SHS_DIR_REV : shs_pkg::SHS_DIR_FWD;

  AST_NO_SOFT_LIMIT: assert property (home_busy_o |-> !motion_o.soft_limit_en)
    else $error("soft limit on while homing");
  AST_TABLE1_TC: assert property (motion_o.run |->
    motion_o.accel_tc == param_i.accel_tc_table1 && motion_o.decel_tc == param_i.decel_tc_table1)
    else $error("time constants differ from table entry one");
  AST_DOGLESS_DIR: assert property (dl && hr |-> motion_o.dir == hd)
    else $error("dogless travel in wrong direction");
  AST_DOGLESS_SPEED: assert property (dl && hr |->
    motion_o.speed == param_i.homing_speed_param)
    else $error("dogless travel not at homing speed");
  AST_INDEX_STOP: assert property (dl && hr && $rose(index_pulse_i) |->
    ##[2:6] (!motion_o.run && target_valid_o))
    else $error("index pulse did not end the seek");
  AST_AUTO_POS: assert property (motion_o.run && motion_o.dir == shs_pkg::SHS_DIR_NONE |->
    motion_o.speed == param_i.homing_speed_param && target_valid_o && home_established_o)
    else $error("bad automatic positioning run");
  AST_LOAD: assert property (pos_load_o |->
    pos_load_value_o == param_i.home_position_data_param && home_established_o)
    else $error("wrong position load at completion");
  AST_LOAD_ONCE: assert property (pos_load_o |=> !pos_load_o)
    else $error("position load longer than one cycle");
  AST_ALARM_STOP: assert property (home_return_incomplete_alarm_o |-> !motion_o.run)
    else $error("motion while alarm raised");
  AST_EST_KEEP: assert property (home_established_o |=> home_established_o)
    else $error("home flag lost without reset");
endmodule // shs_props

bind shs_sequencer shs_props u_props (
  .mclk_i(mclk_i), .arst_n_i(arst_n_i), .param_i(param_i), .index_pulse_i(index_pulse_i),
  .motion_o(motion_o), .target_valid_o(target_valid_o), .pos_load_o(pos_load_o),
  .pos_load_value_o(pos_load_value_o), .home_established_o(home_established_o),
  .home_busy_o(home_busy_o),
  .home_return_incomplete_alarm_o(home_return_incomplete_alarm_o));

// ---- sim/shs_axis_model.sv ----
`timescale 1ns/100ps
// axis: one count a cycle, index every 32 counts, dog window, stroke ends
module shs_axis_model #(
  parameter int LIM = 300
) (
  input  wire logic                 mclk_i,
  input  wire logic                 arst_n_i,
  input  wire shs_pkg::shs_motion_t motion_i,
  input  wire logic [31:0]          target_pos_i,
  input  wire logic                 target_valid_i,
  input  wire logic                 ld_i,
  input  wire logic [31:0]          ld_val_i,
  input  wire logic [31:0]          dog_lo_i,
  input  wire logic [31:0]          dog_hi_i,
  output logic      [31:0]          pos_o,
  output logic                      index_o,
  output logic                      dog_o,
  output logic                      fwd_end_o,
  output logic                      rev_end_o,
  output logic                      done_o
);
  logic seek;
  // target seek only when no directed run; index two cycles wide at speed one
  assign seek = target_valid_i && (!motion_i.run || motion_i.dir == shs_pkg::SHS_DIR_NONE);
  assign index_o = pos_o[4:1] == 4'h0;
  assign dog_o = $signed(pos_o) >= $signed(dog_lo_i) && $signed(pos_o) <= $signed(dog_hi_i);
  assign fwd_end_o = $signed(pos_o) >= LIM;
  assign rev_end_o = $signed(pos_o) <= -LIM;
  assign done_o = (!motion_i.run || motion_i.dir == shs_pkg::SHS_DIR_NONE)
                  && (!target_valid_i || pos_o == target_pos_i);
  // position counter, loads win over motion
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      pos_o <= 32'h0000_0000;
    else if (ld_i)
      pos_o <= ld_val_i;
    else if (seek && pos_o != target_pos_i)
      pos_o <= ($signed(pos_o) < $signed(target_pos_i)) ? pos_o + 32'h1 : pos_o - 32'h1;
    else if (motion_i.run && motion_i.dir == shs_pkg::SHS_DIR_FWD)
      pos_o <= pos_o + 32'h1;
    else if (motion_i.run && motion_i.dir == shs_pkg::SHS_DIR_REV)
      pos_o <= pos_o - 32'h1;
  end
endmodule // shs_axis_model

// ---- sim/tb_servo_homing_sequencer.sv ----
`timescale 1ns/100ps
// bench: dogless homing, auto positioning, refusals, dog returns
module tb_servo_homing_sequencer;
  localparam int LIM = 300;
  logic                 mclk_i = 1'b0;
  logic                 arst_n_i = 1'b0;
  logic                 ams, fs, rs, ld, tval, pld, est, busy, alarm, idx, dog, forward_stroke_end, reverse_stroke_end, done;
  logic [3:0]           bcd;
  logic [7:0]           pts;
  logic [15:0]          lf = 16'h0014;
  logic [31:0]          ldv, pos, dlo, dhi, tpos, lval, home;
  shs_pkg::shs_param_t  p;
  shs_pkg::shs_motion_t mo;
  int                   num_errors = 0;
  int                   comparisons = 0;
  int                   cyc = 0;

  shs_sequencer DUT (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .param_i(p), .input_filter_time_param_i(8'h03),
    .auto_manual_select_i(ams), .point_table_select_i(pts), .bcd_digit_select_i(bcd),
    .forward_start_i(fs), .reverse_start_input_i(rs), .proximity_dog_i(dog),
    .forward_stroke_end_i(forward_stroke_end), .reverse_stroke_end_i(reverse_stroke_end), .index_pulse_i(idx),
    .motion_done_i(done), .feedback_pos_i(pos), .motion_o(mo), .target_pos_o(tpos),
    .target_valid_o(tval), .pos_load_o(pld), .pos_load_value_o(lval),
    .home_established_o(est), .home_busy_o(busy), .home_return_incomplete_alarm_o(alarm));
  shs_axis_model #(.LIM(LIM)) u_axis (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .motion_i(mo), .target_pos_i(tpos),
    .target_valid_i(tval), .ld_i(ld | pld), .ld_val_i(pld ? lval : ldv), .dog_lo_i(dlo),
    .dog_hi_i(dhi), .pos_o(pos), .index_o(idx), .dog_o(dog), .fwd_end_o(forward_stroke_end),
    .rev_end_o(reverse_stroke_end), .done_o(done));

  // clock and hang guard
  always #10 mclk_i = ~mclk_i;
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      num_errors++;
      finish_test();
    end
  end

  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic reset();
    arst_n_i = 1'b0;
    tick(10);
    arst_n_i = 1'b1;
    tick(2);
  endtask
  task automatic place(input logic [31:0] v);
    ld = 1'b1;
    ldv = v;
    tick(1);
    ld = 1'b0;
  endtask
  // start held well past sync and filter delay
  task automatic start(input logic rev);
    fs = !rev;
    rs = rev;
    tick(12);
    fs = 1'b0;
    rs = 1'b0;
    tick(12);
  endtask
  // bounded wait: 0 idle, 1 target valid, 2 alarm; a lapse counts as a mismatch
  task automatic wait_for(input int sel);
    int i;
    for (i = 0; i < 2000; i++)
    begin
      if ((sel == 0 && busy === 1'b0) || (sel == 1 && tval === 1'b1)
          || (sel == 2 && alarm === 1'b1))
        break;
      tick(1);
    end
    if (i == 2000)
      num_errors++;
    tick(1); // the position load lands one edge after busy drops
  endtask
  // start offset far from the index window in either direction
  task automatic dogless(input logic rev);
    logic [15:0] r;
    logic [31:0] s;
    logic [31:0] ix;
    logic [31:0] lag;
    r = rnd();
    p.homing_type_param = {r[15:4], 4'ha};
    p.homing_direction_param = rev;
    p.home_shift_param = {28'h0000000, r[7:4]};
    home = {16'h0000, rnd()};
    p.home_position_data_param = home;
    s = {24'h000000, r[2:0], rev ? 5'h1e : 5'h02};
    ix = rev ? {s[31:5], 5'h01} : {s[31:5] + 27'h1, 5'h00};
    place(s);
    start(1'b0);
    wait_for(1);
    lag = tpos - p.home_shift_param - ix;
    check((rev ? -lag : lag) < 32'h8, 1'b1);
    wait_for(0);
    check(pos, home);
    check(est, 1'b1);
  endtask

  initial
  begin
    {ams, fs, rs, ld, ldv} = {1'b1, 35'h0};
    pts = 8'h00;
    bcd = 4'h0;
    dlo = 32'h0001_0000;
    dhi = 32'h0001_0010;
    p = '0;
    p.homing_speed_param = rnd();
    p.creep_speed_param = rnd();
    p.accel_tc_table1 = rnd();
    p.decel_tc_table1 = rnd();
    p.pos_limit_min = 32'h8000_0000;
    p.pos_limit_max = 32'h7fff_ffff;
    reset();
    dogless(1'b0);
    dogless(1'b1);
    // reverse start returns to home, then refused beyond the range
    place(home + 32'h28);
    start(1'b1);
    wait_for(0);
    check(pos, home);
    p.pos_limit_max = home + 32'h0a;
    place(home + 32'h28);
    start(1'b1);
    check(pos, home + 32'h28);
    // power-on drops the home flag, so reverse start does nothing
    p.pos_limit_max = 32'h7fff_ffff;
    reset();
    check(est, 1'b0);
    place(home + 32'h28);
    start(1'b1);
    check(pos, home + 32'h28);
    // nonzero table select or bcd digits keep homing mode off
    pts = 8'h01;
    start(1'b0);
    check(busy, 1'b0);
    {pts, p.bcd_mode, bcd} = {8'h00, 1'b1, 4'h2};
    start(1'b0);
    check(busy, 1'b0);
    {p.bcd_mode, bcd, p.homing_type_param} = {1'b0, 4'h0, 16'h0008};
    p.homing_direction_param = 1'b0; // forward homing for the dog cases
    // starting on the dog backs off against the homing direction
    {dlo, dhi} = {32'hffff_ffd8, 32'h0000_0028};
    place(32'h0);
    start(1'b0);
    check(mo.dir, shs_pkg::SHS_DIR_REV);
    ams = 1'b0;
    tick(12);
    ams = 1'b1;
    // no dog at all: reverse at forward end, alarm at reverse end
    {dlo, dhi} = {32'h0001_0000, 32'h0001_0010};
    place(32'h0);
    start(1'b0);
    wait_for(2);
    check(alarm, 1'b1);
    check($signed(pos) <= -LIM, 1'b1);
    // a fresh start only clears the alarm; homing needs one more start
    start(1'b0);
    check(alarm, 1'b0);
    // beyond the dog: reverse, stop past its front, home again
    {dlo, dhi} = {32'h0000_0014, 32'h0000_003c};
    place(32'h0000_0064);
    start(1'b0);
    wait_for(0);
    check(est, 1'b1);
    check(pos, home);
    // absolute mode keeps home across power-on
    p.absolute_mode = 1'b1;
    reset();
    check(est, 1'b1);
    finish_test();
  end
endmodule // tb_servo_homing_sequencer
